/* bench/test_timer_pwm_channels.sv */
// self-checking bench for the two-channel pwm timer
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module test_timer_pwm_channels
  import tpw_pkg::*;
;
  logic         pclk, presetn, pready, pslverr, timer_irq;
  logic         wait_mode, dbg_break, bce, ext_clk, run, smp_req, bad;
  tpw_apb_req_t req;
  logic [31:0]  prdata;
  logic [2:0]   pin_in, pin_out, pin_oe, port_dout, port_dir;
  logic [7:0]   hi_cnt;
  logic [15:0]  lfsr;
  logic [32:0]  exp_q[$];
  logic [32:0]  exp_v;
  int           err_count, checked, cyc, c;

  tpw_timer DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode), .dbg_break(dbg_break),
    .break_clear_enable(bce), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_data_out(port_dout), .port_direction(port_dir), .timer_irq(timer_irq));
  tpw_load LOAD (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_clk(ext_clk),
    .run(run), .pin_in(pin_in), .hi_cnt(hi_cnt));

  always #20 pclk = ~pclk;
  function automatic logic [15:0] lfsr_nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // random port data keeps the passthrough path busy
  always @(posedge pclk) begin
    lfsr      <= lfsr_nxt(lfsr);
    port_dout <= lfsr[2:0];
  end
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({bad, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic smp(input logic [31:0] e);
    exp_q.push_back({1'b0, e});
    smp_req <= 1'b1;
    @(posedge pclk);
    smp_req <= 1'b0;
  endtask
  // settle two periods, then count high cycles over ten periods
  task automatic measure(input logic [31:0] e);
    repeat (8) @(posedge pclk);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    run <= 1'b0;
    smp(e);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    // pop once: the macro names the expectation twice
    if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) begin
      exp_v = exp_q.pop_front();
      `CHK("prdata", exp_v, {pslverr, prdata})
    end else if (smp_req) begin
      exp_v = exp_q.pop_front();
      `CHK("pins", exp_v, {21'h0, timer_irq, pin_oe, hi_cnt})
    end
  end
  task automatic end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; req = '0; wait_mode = 0; dbg_break = 0; bce = 0;
    port_dir = 3'b101; port_dout = 3'h0; ext_clk = 0; run = 0; smp_req = 0;
    lfsr = 16'h315C; err_count = 0; checked = 0; cyc = 0; bad = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h40, 32'h20);
    rd(8'h50, 32'hFF);
    wr(8'h40, 32'h30);
    wr(8'h50, 32'h00);
    wr(8'h54, 32'h03);
    wr(8'h5C, 32'h00);
    wr(8'h60, 32'h01);
    wr(8'h58, 32'h1A);
    wr(8'h40, 32'h00);
    measure(32'h70A);
    for (int i = 0; i < 4; i++) begin
      c = int'(lfsr[1:0]);
      wr(8'h60, c);
      measure(32'h700 + c * 10);
    end
    wr(8'h58, 32'h18);
    measure(32'h700);
    wr(8'h58, 32'h19);
    measure(32'h728);
    wr(8'h60, 32'h01);
    wr(8'h58, 32'h1E);
    measure(32'h71E);
    wr(8'h58, 32'h3A);
    measure(32'h70A);
    wr(8'h68, 32'h00);
    wr(8'h6C, 32'h03);
    measure(32'h71E);
    wr(8'h60, 32'h02);
    measure(32'h714);
    rd(8'h58, 32'hBA);
    wr(8'h64, 32'h1A);
    rd(8'h64, 32'h00);
    port_dir <= 3'b001;
    @(posedge pclk);
    smp(32'h300);
    port_dir <= 3'b101;
    // halt first so no wrap drops the armed read step
    wr(8'h40, 32'h30);
    rd(8'h40, 32'hA0);
    wr(8'h40, 32'h70);
    dbg_break <= 1'b1;
    wr(8'h40, 32'h40);
    repeat (10) @(posedge pclk);
    rd(8'h48, 32'h00);
    rd(8'h4C, 32'h00);
    rd(8'h40, 32'h40);
    dbg_break <= 1'b0;
    repeat (8) @(posedge pclk);
    smp(32'hF00);
    wr(8'h40, 32'h60);
    rd(8'h40, 32'hE0);
    dbg_break <= 1'b1;
    wr(8'h40, 32'h60);
    rd(8'h40, 32'hE0);
    dbg_break <= 1'b0;
    wr(8'h40, 32'h60);
    rd(8'h40, 32'h60);
    smp(32'h700);
    wr(8'h50, 32'h00);
    wr(8'h40, 32'h40);
    repeat (12) @(posedge pclk);
    wr(8'h40, 32'h60);
    rd(8'h40, 32'h60);
    wait_mode <= 1'b1;
    bad = 1'b1;
    rd(8'h40, 32'h00);
    wr(8'h40, 32'h07);
    wait_mode <= 1'b0;
    bad = 1'b0;
    rd(8'h40, 32'h60);
    wr(8'h54, 32'hFF);
    wr(8'h40, 32'h27);
    smp(32'h600);
    wr(8'h40, 32'h17);
    repeat (5) begin
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    rd(8'h4C, 32'h05);
    // divide by four, counter keeps running in wait
    wr(8'h40, 32'h12);
    wait_mode <= 1'b1;
    repeat (17) @(posedge pclk);
    wait_mode <= 1'b0;
    rd(8'h4C, 32'h04);
    wr(8'h40, 32'h20);
    smp(32'h700);
    bad = 1'b1;
    rd(8'h44, 32'h00);
    rd(8'h41, 32'h00);
    end_sim();
  end
endmodule // test_timer_pwm_channels

/* bench/tpw_load.sv */
// external load model on the timer's three shared port pins
`timescale 1ns/1ns
module tpw_load (
  // clock
  input  wire logic       pclk,
  // pins from the timer
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  // count clock source and measurement window
  input  wire logic       ext_clk,
  input  wire logic       run,
  // resolved pin levels and high-cycle count of channel 0 pin
  output logic      [2:0] pin_in,
  output logic      [7:0] hi_cnt
);
  logic [2:0] last = 3'h0;
  // undriven pins 1 and 2 float: inverse of last level, so a stale value never passes; undriven pin 0 takes ext_clk
  always_comb begin
    pin_in[0] = pin_oe[0] ? pin_out[0] : ext_clk;
    pin_in[1] = pin_oe[1] ? pin_out[1] : ~last[1];
    pin_in[2] = pin_oe[2] ? pin_out[2] : ~last[2];
  end
  ////////////////////////////////////////////////////////////////
  // run is low from time zero, so the count starts cleared
  always_ff @(posedge pclk) begin
    last   <= pin_in;
    hi_cnt <= run ? hi_cnt + {7'h00, pin_in[1]} : 8'h00;
  end
endmodule // tpw_load

/* common/tpw_defines.svh */
// register indices, field positions, reset values and codes for the pwm timer
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

// register indices; byte address is four times the index
`define TPW_IDX_CTRL    6'h10
`define TPW_IDX_CNT_HI  6'h12
`define TPW_IDX_CNT_LO  6'h13
`define TPW_IDX_MOD_HI  6'h14
`define TPW_IDX_MOD_LO  6'h15
`define TPW_IDX_CH0_CTL 6'h16
`define TPW_IDX_CH0_HI  6'h17
`define TPW_IDX_CH0_LO  6'h18
`define TPW_IDX_CH1_CTL 6'h19
`define TPW_IDX_CH1_HI  6'h1A
`define TPW_IDX_CH1_LO  6'h1B

// field positions of timer and channel control words; only flag and ie are shared by both
`define TPW_B_FLAG  7
`define TPW_B_IE    6
`define TPW_B_HALT  5
`define TPW_B_CLR   4
`define TPW_B_LINK  5
`define TPW_B_MSA   4
`define TPW_B_ELSH  3
`define TPW_B_ELSL  2
`define TPW_B_TOV   1
`define TPW_B_MAX   0

// reset values and codes
`define TPW_MOD_RST   16'hFFFF
`define TPW_CNT_ZERO  16'h0000
`define TPW_PS_EXT    3'h7
`define TPW_ELS_OFF   2'h0
`define TPW_ELS_TGL   2'h1
`define TPW_ELS_CLR   2'h2
`define TPW_ELS_SET   2'h3
`define TPW_DIV_ZERO  6'h00

`endif

/* common/tpw_pkg.sv */
// types shared by the pwm timer modules
package tpw_pkg;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tpw_apb_req_t;

  typedef struct packed {
    logic       ie;
    logic       msb;
    logic       msa;
    logic [1:0] els;
    logic       tov;
    logic       cmax;
  } tpw_chctl_t;

  typedef struct packed {
    logic [15:0]           cnt;
    logic [15:0]           modv;
    logic [1:0][15:0]      cmp;
    tpw_chctl_t [1:0]      ch;
    logic                  rollover_flag;
    logic                  rollover_irq_enable;
    logic                  halt;
    logic [2:0]            ps;
    logic                  mod_inh;
    logic                  arm_tof;
    logic [1:0]            chf;
    logic [1:0]            arm_ch;
    logic [1:0]            out;
    logic                  sel;
    logic                  last;
    logic                  latched;
    logic [7:0]            lo_latch;
    logic [2:0]            pin_prev;
    logic                  irq;
    logic [31:0]           prdata;
  } tpw_state_t;

  typedef struct packed {
    logic [5:0] div;
  } tpw_pre_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } tpw_sync_state_t;

endpackage

/* hw/tpw_prescale.sv */
// count-clock prescaler: bus clock divided by 1..64 or external pin edges
`timescale 1ns/1ns
`include "tpw_defines.svh"
module tpw_prescale
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       clr,
  input  wire logic [2:0] sel,
  input  wire logic       ext_rise,
  // one-cycle count enable
  output logic            tick
);

  tpw_pre_state_t s_r;
  tpw_pre_state_t s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.div = clr ? `TPW_DIV_ZERO : s_r.div + 6'h01;
  end

  // sel 0 to 6 divide by 2^sel: pulse when the low sel bits are all ones; sel 7 takes external edges
  always_comb begin
    case (sel)
      3'h0:        tick = 1'b1;
      3'h1:        tick = s_r.div[0];
      3'h2:        tick = &s_r.div[1:0];
      3'h3:        tick = &s_r.div[2:0];
      3'h4:        tick = &s_r.div[3:0];
      3'h5:        tick = &s_r.div[4:0];
      3'h6:        tick = &s_r.div[5:0];
      `TPW_PS_EXT: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // tpw_prescale

/* hw/tpw_sync.sv */
// two-flop synchroniser for the three shared port pins
`timescale 1ns/1ns
module tpw_sync
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pins in, synchronised out
  input  wire logic [2:0] pin_async,
  output logic      [2:0] pin_sync
);

  tpw_sync_state_t s_r;
  tpw_sync_state_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = pin_async;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_sync = s_r.s2;

endmodule // tpw_sync

/* hw/tpw_timer.sv */
// two-channel 16-bit pwm timer with apb register access
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "tpw_defines.svh"
module tpw_timer
  import tpw_pkg::*;
(
  // apb slave
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire tpw_apb_req_t apb_req,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // system state
  input  wire logic         wait_mode,
  input  wire logic         dbg_break,
  input  wire logic         break_clear_enable,
  // port pins: bit 0 external count clock, bit 1 channel 0, bit 2 channel 1
  input  wire logic [2:0]   pin_in,
  output logic      [2:0]   pin_out,
  output logic      [2:0]   pin_oe,
  // port register side
  input  wire logic [2:0]   port_data_out,
  input  wire logic [2:0]   port_direction,
  // interrupt request, also the wake request
  output logic              timer_irq
);

  tpw_state_t s_r;
  tpw_state_t s_nxt;

  logic [2:0]  pin_sync;
  logic [5:0]  idx;
  logic        hit;
  logic        acc_done;
  logic        wr;
  logic        rd;
  logic [7:0]  wdat;
  logic        can_clr;
  logic        tick;
  logic        run;
  logic        ovf;
  logic        cnt_clr;
  logic        link;
  logic        ext_sel;
  logic [15:0] cnt_adv;
  logic [7:0]  rd_mux;
  logic [1:0]  oc_mode;
  logic [1:0]  ic_mode;
  logic [1:0]  match;
  logic [1:0]  ev;
  logic [1:0][15:0] cmp_val;

  ////////////////////////////////////////////////////////////////////////////
  tpw_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (pin_in),
    .pin_sync  (pin_sync)
  );

  tpw_prescale u_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .clr      (cnt_clr),
    .sel      (s_r.ps),
    .ext_rise (pin_sync[0] & ~s_r.pin_prev[0]),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; no wait states, so access completes on its first access cycle
  assign idx      = apb_req.paddr[7:2];
  assign acc_done = apb_req.psel & apb_req.penable;
  assign wdat     = apb_req.pwdata[7:0];
  always_comb begin
    case (idx)
      `TPW_IDX_CTRL, `TPW_IDX_CNT_HI, `TPW_IDX_CNT_LO, `TPW_IDX_MOD_HI,
      `TPW_IDX_MOD_LO, `TPW_IDX_CH0_CTL, `TPW_IDX_CH0_HI, `TPW_IDX_CH0_LO,
      `TPW_IDX_CH1_CTL, `TPW_IDX_CH1_HI, `TPW_IDX_CH1_LO:
        hit = (apb_req.paddr[1:0] == 2'h0);
      default:
        hit = 1'b0;
    endcase
  end
  assign wr      = acc_done & apb_req.pwrite & hit & ~wait_mode;
  assign rd      = acc_done & ~apb_req.pwrite & hit & ~wait_mode;
  assign pready  = 1'b1;
  assign pslverr = acc_done & (~hit | wait_mode);
  assign prdata  = s_r.prdata;
  assign can_clr = ~dbg_break | break_clear_enable;

  ////////////////////////////////////////////////////////////////////////////
  // counter timing
  assign cnt_clr = wr & (idx == `TPW_IDX_CTRL) & wdat[`TPW_B_CLR];
  assign run     = tick & ~s_r.halt & ~dbg_break;
  assign cnt_adv = (s_r.cnt == s_r.modv) ? `TPW_CNT_ZERO : s_r.cnt + 16'h0001;
  assign ovf     = run & (s_r.cnt == s_r.modv);
  assign link    = s_r.ch[0].msb;
  assign ext_sel = (s_r.ps == `TPW_PS_EXT);

  ////////////////////////////////////////////////////////////////////////////
  // per-channel mode decode, compare and capture
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic en;
      logic buf_ch;
      logic rise;
      logic fall;
      assign en     = (gi == 0) | ~link;
      assign buf_ch = (gi == 0) & link;
      assign cmp_val[gi] = buf_ch ? s_r.cmp[s_r.sel] : s_r.cmp[gi];
      assign oc_mode[gi] = en & (s_r.ch[gi].els != `TPW_ELS_OFF) &
                           (buf_ch | s_r.ch[gi].msa);
      assign ic_mode[gi] = en & (s_r.ch[gi].els != `TPW_ELS_OFF) &
                           ~buf_ch & ~s_r.ch[gi].msa;
      // continuous compare, a late overwrite can skip a period
      assign match[gi] = run & oc_mode[gi] & (cnt_adv == cmp_val[gi]);
      assign rise      = pin_sync[gi+1] & ~s_r.pin_prev[gi+1];
      assign fall      = ~pin_sync[gi+1] & s_r.pin_prev[gi+1];
      assign ev[gi]    = match[gi] | (ic_mode[gi] &
                         ((s_r.ch[gi].els[0] & rise) | (s_r.ch[gi].els[1] & fall)));
      // pin owned by the channel, else plain port pin
      assign pin_out[gi+1] = oc_mode[gi] ? s_r.out[gi] : port_data_out[gi+1];
      assign pin_oe[gi+1]  = oc_mode[gi] | (~ic_mode[gi] & port_direction[gi+1]);
    end
  endgenerate

  // external count pin is forced to input when it is the count source
  assign pin_out[0] = port_data_out[0];
  assign pin_oe[0]  = ~ext_sel & port_direction[0];

  ////////////////////////////////////////////////////////////////////////////
  // read mux, sampled in the setup cycle so prdata leaves a flop
  always_comb begin
    case (idx)
      `TPW_IDX_CTRL:    rd_mux = {s_r.rollover_flag, s_r.rollover_irq_enable, s_r.halt, 2'h0, s_r.ps};
      `TPW_IDX_CNT_HI:  rd_mux = s_r.cnt[15:8];
      `TPW_IDX_CNT_LO:  rd_mux = s_r.latched ? s_r.lo_latch : s_r.cnt[7:0];
      `TPW_IDX_MOD_HI:  rd_mux = s_r.modv[15:8];
      `TPW_IDX_MOD_LO:  rd_mux = s_r.modv[7:0];
      `TPW_IDX_CH0_CTL: rd_mux = {s_r.chf[0], s_r.ch[0]};
      `TPW_IDX_CH0_HI:  rd_mux = s_r.cmp[0][15:8];
      `TPW_IDX_CH0_LO:  rd_mux = s_r.cmp[0][7:0];
      `TPW_IDX_CH1_CTL: rd_mux = {s_r.chf[1], s_r.ch[1]};
      `TPW_IDX_CH1_HI:  rd_mux = s_r.cmp[1][15:8];
      `TPW_IDX_CH1_LO:  rd_mux = s_r.cmp[1][7:0];
      default:          rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       o;
    logic [5:0] ctl_idx;
    logic [5:0] hi_idx;
    logic [5:0] lo_idx;
    s_nxt          = s_r;
    o              = 1'b0;
    ctl_idx        = `TPW_IDX_CH0_CTL;
    hi_idx         = `TPW_IDX_CH0_HI;
    lo_idx         = `TPW_IDX_CH0_LO;
    s_nxt.pin_prev = pin_sync;
    if (apb_req.psel & ~apb_req.penable) begin
      s_nxt.prdata = (hit & ~wait_mode) ? {24'h000000, rd_mux} : 32'h00000000;
    end
    // counter
    if (cnt_clr) begin
      s_nxt.cnt = `TPW_CNT_ZERO;
    end else if (run) begin
      s_nxt.cnt = cnt_adv;
    end
    // timer control register
    if (wr & (idx == `TPW_IDX_CTRL)) begin
      s_nxt.rollover_irq_enable = wdat[`TPW_B_IE];
      s_nxt.halt = wdat[`TPW_B_HALT];
      s_nxt.ps   = wdat[2:0];
      if (~wdat[`TPW_B_FLAG] & s_r.arm_tof & can_clr) begin
        s_nxt.rollover_flag     = 1'b0;
        s_nxt.arm_tof = 1'b0;
      end
    end
    if (rd & (idx == `TPW_IDX_CTRL) & s_r.rollover_flag & can_clr) begin
      s_nxt.arm_tof = 1'b1;
    end
    // counter read latches the low byte until it is read
    if (rd & (idx == `TPW_IDX_CNT_HI)) begin
      s_nxt.latched  = 1'b1;
      s_nxt.lo_latch = s_r.cnt[7:0];
    end
    if (rd & (idx == `TPW_IDX_CNT_LO)) begin
      s_nxt.latched = 1'b0;
    end
    // modulo
    if (wr & (idx == `TPW_IDX_MOD_HI)) begin
      s_nxt.modv[15:8] = wdat;
      s_nxt.mod_inh    = 1'b1;
    end
    if (wr & (idx == `TPW_IDX_MOD_LO)) begin
      s_nxt.modv[7:0] = wdat;
      s_nxt.mod_inh   = 1'b0;
    end
    // channels
    for (int i = 0; i < 2; i++) begin
      ctl_idx = (i == 0) ? `TPW_IDX_CH0_CTL : `TPW_IDX_CH1_CTL;
      hi_idx  = (i == 0) ? `TPW_IDX_CH0_HI : `TPW_IDX_CH1_HI;
      lo_idx  = (i == 0) ? `TPW_IDX_CH0_LO : `TPW_IDX_CH1_LO;
      if (wr & (idx == ctl_idx) & ((i == 0) | ~link)) begin
        s_nxt.ch[i].ie   = wdat[`TPW_B_IE];
        s_nxt.ch[i].msb  = (i == 0) & wdat[`TPW_B_LINK];
        s_nxt.ch[i].msa  = wdat[`TPW_B_MSA];
        s_nxt.ch[i].els  = wdat[`TPW_B_ELSH:`TPW_B_ELSL];
        s_nxt.ch[i].tov  = wdat[`TPW_B_TOV];
        s_nxt.ch[i].cmax = wdat[`TPW_B_MAX];
        if (~wdat[`TPW_B_FLAG] & s_r.arm_ch[i] & can_clr) begin
          s_nxt.chf[i]    = 1'b0;
          s_nxt.arm_ch[i] = 1'b0;
        end
      end
      if (rd & (idx == ctl_idx) & s_r.chf[i] & can_clr) begin
        s_nxt.arm_ch[i] = 1'b1;
      end
      if (wr & (idx == hi_idx)) begin
        s_nxt.cmp[i][15:8] = wdat;
        s_nxt.last         = (i == 1);
      end
      if (wr & (idx == lo_idx)) begin
        s_nxt.cmp[i][7:0] = wdat;
        s_nxt.last        = (i == 1);
      end
      if (ic_mode[i] & ev[i]) begin
        s_nxt.cmp[i] = s_r.cnt;
      end
      // output level
      o = s_r.out[i];
      if (~oc_mode[i]) begin
        if (s_r.ch[i].els == `TPW_ELS_OFF) begin
          o = ~s_r.ch[i].msa;
        end
      end else begin
        if (ovf & s_r.ch[i].tov) begin
          o = ~o;
        end
        if (match[i]) begin
          case (s_r.ch[i].els)
            `TPW_ELS_TGL: o = ~o;
            `TPW_ELS_CLR: o = 1'b0;
            `TPW_ELS_SET: o = 1'b1;
            default:      o = o;
          endcase
        end
        if (s_r.ch[i].cmax & ~s_r.ch[i].tov) begin
          o = (s_r.ch[i].els != `TPW_ELS_SET);
        end
      end
      s_nxt.out[i] = o;
      // a new event wins over a clear in the same cycle and drops the armed step
      if (ev[i]) begin
        s_nxt.chf[i]    = 1'b1;
        s_nxt.arm_ch[i] = 1'b0;
      end
    end
    // buffered source select
    if (~link) begin
      s_nxt.sel  = 1'b0;
      s_nxt.last = 1'b0;
    end else if (ovf) begin
      s_nxt.sel = s_nxt.last;
    end
    if (ovf & ~s_r.mod_inh) begin
      s_nxt.rollover_flag     = 1'b1;
      s_nxt.arm_tof = 1'b0;
    end
    s_nxt.irq = (s_nxt.rollover_flag & s_nxt.rollover_irq_enable) |
                (s_nxt.chf[0] & s_nxt.ch[0].ie) |
                (s_nxt.chf[1] & s_nxt.ch[1].ie & ~s_nxt.ch[0].msb);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r      <= '0;
      s_r.modv <= `TPW_MOD_RST;
      s_r.halt <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign timer_irq = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_link_sel_last: assert property ((link && ovf) |=> (s_r.sel == $past(s_nxt.last)))
    else $error("buffered source not taken from last written pair");
  a_link_ch0_start: assert property ($rose(link) |-> !s_r.sel)
    else $error("buffered mode did not start on channel 0");
  a_link_pin_free: assert property (link |-> (pin_oe[2] == port_direction[2]))
    else $error("channel 1 pin not released while linked");
  a_link_priority: assert property ((link && s_r.ch[0].els != `TPW_ELS_OFF) |-> oc_mode[0])
    else $error("link bit lost precedence over mode bit");
  a_roll_flag: assert property ((ovf && !s_r.mod_inh) |=> (s_r.rollover_flag ##1 s_r.rollover_flag || !s_r.arm_tof))
    else $error("rollover flag not set on wrap");
  a_mod_inhibit: assert property ((ovf && s_r.mod_inh && !s_r.rollover_flag) |=> !s_r.rollover_flag)
    else $error("rollover flagged while modulo high byte pending");
  a_clear_zero: assert property (cnt_clr |=> (s_r.cnt == `TPW_CNT_ZERO))
    else $error("counter clear did not zero the counter");
  a_break_freeze: assert property ((dbg_break && !cnt_clr) |=> $stable(s_r.cnt))
    else $error("counter moved during break");
  a_halt_freeze: assert property ((s_r.halt && !cnt_clr) |=> $stable(s_r.cnt))
    else $error("counter moved while halted");
  a_break_keep: assert property ((dbg_break && !break_clear_enable && s_r.rollover_flag) |=> s_r.rollover_flag)
    else $error("rollover flag cleared during protected break");
  a_flag_unarmed: assert property ((s_r.chf[0] && !s_r.arm_ch[0]) |=> s_r.chf[0])
    else $error("channel flag cleared without read step");
  a_full_duty: assert property ((oc_mode[0] && s_r.ch[0].cmax && !s_r.ch[0].tov &&
    s_r.ch[0].els == `TPW_ELS_CLR) [*2] |-> s_r.out[0])
    else $error("full duty output not high");
  a_ovf_toggle: assert property ((ovf && oc_mode[0] && s_r.ch[0].tov && !match[0] &&
    !s_r.ch[0].cmax) |=> (s_r.out[0] != $past(s_r.out[0])))
    else $error("output did not toggle on overflow");
  a_ext_input: assert property (ext_sel |-> !pin_oe[0])
    else $error("external clock pin driven while selected");

endmodule // tpw_timer
